/* hw/zac_pkg.sv */
package zac_pkg;

  localparam int ZONES_MAX = 16;
  localparam int ZONE_W    = 4;
  localparam int SETS      = 8;
  localparam int SET_W     = 3;
  localparam int ADDR_W    = 12;

  localparam logic [ADDR_W-1:0] ACC_BASE    = 12'h000;
  localparam logic [ADDR_W-1:0] PSEL_BASE   = 12'h040;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h080;

  localparam logic [7:0] ACC_RESET  = 8'hFF;
  localparam logic [7:0] PSEL_RESET = 8'hFF;

  localparam int PM_HI   = 7;
  localparam int PM_LO   = 6;
  localparam int AUTH_HI = 5;
  localparam int AUTH_LO = 4;
  localparam int ENC_BIT = 3;
  localparam int WLM_BIT = 2;
  localparam int MDF_BIT = 1;
  localparam int PGO_BIT = 0;

  localparam logic [1:0] PM_NONE  = 2'h3;
  localparam logic [1:0] PM_WRITE = 2'h2;

  localparam logic [2:0] SEC_DUAL    = 3'h1;
  localparam logic [2:0] SEC_AUTH_RW = 3'h3;
  localparam logic [2:0] SEC_AUTH_W  = 3'h5;
  localparam logic [2:0] SEC_ENC_RW  = 3'h6;
  localparam logic [2:0] SEC_NONE    = 3'h7;

  localparam int STAT_FACTORY = 0;
  localparam int STAT_CIPHER  = 1;
  localparam int STAT_SKEY    = 2;
  localparam int STAT_FINAL   = 3;
  localparam int STAT_GRANT   = 4;
  localparam int STAT_ERROR   = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    AREA_USER,
    AREA_ANTICOL,
    AREA_MTZ,
    AREA_HWR,
    AREA_SERIAL,
    AREA_ACCESS,
    AREA_DCR,
    AREA_CRYPTO,
    AREA_KEYS,
    AREA_SECRET,
    AREA_PASSWORD,
    AREA_PAC,
    AREA_FORBIDDEN
  } zac_area_e;

  typedef struct packed {
    logic              write;
    zac_area_e         area;
    logic [ZONE_W-1:0] zone;
    logic [SET_W-1:0]  set;
    logic              single_byte;
    logic [2:0]        byte_sel;
    logic [7:0]        lock_byte;
    logic [7:0]        old_data;
    logic [7:0]        new_data;
  } zac_req_s;

  typedef struct packed {
    logic            transport_ok;
    logic [SETS-1:0] write_pw_ok;
    logic [SETS-1:0] read_pw_ok;
    logic            auth_ok;
    logic            encrypt_on;
  } zac_session_s;

  typedef struct packed {
    logic factory_lock_fuse;
    logic cipher_lock_fuse;
    logic secret_key_fuse;
    logic final_lock_fuse;
  } zac_fuse_s;

endpackage

/* hw/zac_zone_check.sv */
`timescale 1ns/10ps
module zac_zone_check (
  input  wire logic       write_i,
  input  wire logic [7:0] access_i,
  input  wire logic       single_byte_i,
  input  wire logic [2:0] byte_sel_i,
  input  wire logic [7:0] lock_byte_i,
  input  wire logic [7:0] old_data_i,
  input  wire logic [7:0] new_data_i,
  input  wire logic       write_pw_ok_i,
  input  wire logic       read_pw_ok_i,
  input  wire logic       auth_ok_i,
  input  wire logic       encrypt_on_i,
  output logic            allow_o,
  output logic [7:0]      data_o
);

  logic [1:0] pm;
  logic [2:0] sec_code;
  logic       pw_ok;
  logic       sec_ok;
  logic       wr_ok;

  assign pm       = {access_i[zac_pkg::PM_HI], access_i[zac_pkg::PM_LO]};
  assign sec_code = {access_i[zac_pkg::AUTH_HI], access_i[zac_pkg::AUTH_LO],
                     access_i[zac_pkg::ENC_BIT]};

  always_comb begin
    unique case (pm) // [RULE12]
      zac_pkg::PM_NONE:  pw_ok = 1'b1;
      zac_pkg::PM_WRITE: pw_ok = !write_i || write_pw_ok_i;
      default:           pw_ok = write_i ? write_pw_ok_i : (read_pw_ok_i || write_pw_ok_i);
    endcase
  end

  always_comb begin
    case (sec_code) // [RULE14] [RULE15]
      zac_pkg::SEC_NONE:    sec_ok = 1'b1;
      zac_pkg::SEC_DUAL:    sec_ok = auth_ok_i;
      zac_pkg::SEC_AUTH_RW: sec_ok = auth_ok_i;
      zac_pkg::SEC_AUTH_W:  sec_ok = !write_i || auth_ok_i;
      zac_pkg::SEC_ENC_RW:  sec_ok = encrypt_on_i;
      default:              sec_ok = 1'b0;
    endcase
  end

  // Lock bit n guards byte n of the page, the lock byte itself included
  always_comb begin
    wr_ok = 1'b1;
    if (!access_i[zac_pkg::MDF_BIT]) begin
      wr_ok = 1'b0; // [RULE17]
    end
    if (!access_i[zac_pkg::WLM_BIT] && !(single_byte_i && lock_byte_i[byte_sel_i])) begin
      wr_ok = 1'b0; // [RULE16]
    end
    if (!access_i[zac_pkg::PGO_BIT] && !single_byte_i) begin
      wr_ok = 1'b0; // [RULE18]
    end
  end

  assign allow_o = pw_ok && sec_ok && (!write_i || wr_ok);
  // Program only can clear bits but never set them
  assign data_o  = access_i[zac_pkg::PGO_BIT] ? new_data_i : (old_data_i & new_data_i); // [RULE18]

endmodule

/* hw/zac_top.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
// Contract
// [RULE1] Transport-password areas open only after that password was checked.
// [RULE2] A set's write password opens only that set's counters and passwords.
// [RULE3] Areas needing encryption refuse access until encryption is active.
// [RULE4] Serial number and hardware revision: always readable, never writable.
// [RULE5] Crypto registers readable; writes need transport password, forbidden once key fuse blown.
// [RULE6] Write rights follow fuses per area; test area open, forbidden area closed.
// [RULE7] Each zone has access and password-select registers, both defaulting open.
// [RULE8] Zone i uses access register i and password-select register i.
// [RULE9] Each zone access register resets to all ones, no security feature.
// [RULE10] Access bits 7..0: password mode, auth mode, encrypt, lock, modify, program-only.
// [RULE11] A written access register governs the very next access to its zone.
// [RULE12] Password mode 11 none, 10 write password for writes, 0x both.
// [RULE13] Password set checked is the zone's password-select value.
// [RULE14] Auth and encrypt bits select the security mode; defaults require nothing.
// [RULE15] Codes 001,011,101 need authentication, 110 encryption, 111 none, others refused; the code asks authentication for 101 on writes only.
// [RULE16] Write lock mode: page lock byte guards each byte; single-byte writes only.
// [RULE17] Modify forbidden clear refuses every write to the zone.
// [RULE18] Program only clear: writes only clear bits, single-byte writes only.
// [RULE19] Refused requests change nothing and answer with error instead of data.
// [RULE20] Reader validates passwords and activates encryption before protected access.
module zac_top #(
  parameter int NUM_ZONES = zac_pkg::ZONES_MAX
) (
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_n_i,
  input  wire logic [zac_pkg::ADDR_W-1:0]     s_axi_awaddr_i,
  input  wire logic                           s_axi_awvalid_i,
  output logic                                s_axi_awready_o,
  input  wire logic [31:0]                    s_axi_wdata_i,
  input  wire logic [3:0]                     s_axi_wstrb_i,
  input  wire logic                           s_axi_wvalid_i,
  output logic                                s_axi_wready_o,
  output logic [1:0]                          s_axi_bresp_o,
  output logic                                s_axi_bvalid_o,
  input  wire logic                           s_axi_bready_i,
  input  wire logic [zac_pkg::ADDR_W-1:0]     s_axi_araddr_i,
  input  wire logic                           s_axi_arvalid_i,
  output logic                                s_axi_arready_o,
  output logic [31:0]                         s_axi_rdata_o,
  output logic [1:0]                          s_axi_rresp_o,
  output logic                                s_axi_rvalid_o,
  input  wire logic                           s_axi_rready_i,
  input  wire logic                           req_valid_i,
  input  wire zac_pkg::zac_req_s              req_i,
  input  wire zac_pkg::zac_session_s          session_i,
  input  wire zac_pkg::zac_fuse_s             fuses_i,
  output logic                                resp_valid_o,
  output logic                                resp_grant_o,
  output logic                                resp_error_o,
  output logic [7:0]                          resp_data_o
);

  if (NUM_ZONES < 1 || NUM_ZONES > zac_pkg::ZONES_MAX) begin : g_bad_zones
    $error("NUM_ZONES out of range");
  end

  logic [7:0]                 acc_r [NUM_ZONES];
  logic [7:0]                 psel_r [NUM_ZONES];
  logic                       aw_held_r;
  logic [zac_pkg::ADDR_W-1:0] awaddr_r;
  logic                       w_held_r;
  logic [7:0]                 wdata_r;
  logic                       wstrb0_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic                       rvalid_r;
  logic [31:0]                rdata_r;
  logic [1:0]                 rresp_r;
  logic                       resp_valid_r;
  logic                       resp_grant_r;
  logic                       resp_error_r;
  logic [7:0]                 resp_data_r;
  logic                       do_write;
  logic                       wr_acc_hit;
  logic                       wr_psel_hit;
  logic [zac_pkg::ZONE_W-1:0] wr_idx;
  logic [zac_pkg::ZONE_W-1:0] rd_idx;
  logic [31:0]                rd_data;
  logic                       rd_hit;
  logic                       zone_in_range;
  logic [7:0]                 zone_acc;
  logic [zac_pkg::SET_W-1:0]  zone_set;
  logic                       zone_allow;
  logic [7:0]                 zone_data;
  logic                       allow;
  logic                       enc_phase;
  logic                       sky_blown;
  logic                       per_blown;
  logic                       tpw;
  logic                       own_set_wpw;

  function automatic logic idx_ok(input logic [zac_pkg::ZONE_W-1:0] idx);
    idx_ok = {1'b0, idx} < (zac_pkg::ZONE_W+1)'(NUM_ZONES);
  endfunction

  // AXI4-Lite write: address and data latched independently, either order
  assign s_axi_awready_o = !aw_held_r && !bvalid_r;
  assign s_axi_wready_o  = !w_held_r && !bvalid_r;
  assign do_write        = aw_held_r && w_held_r && !bvalid_r;
  assign wr_idx          = awaddr_r[zac_pkg::ZONE_W+1:2];
  assign wr_acc_hit      = awaddr_r[zac_pkg::ADDR_W-1:6] == zac_pkg::ACC_BASE[zac_pkg::ADDR_W-1:6]
                           && awaddr_r[1:0] == 2'h0 && idx_ok(wr_idx);
  assign wr_psel_hit     = awaddr_r[zac_pkg::ADDR_W-1:6] == zac_pkg::PSEL_BASE[zac_pkg::ADDR_W-1:6]
                           && awaddr_r[1:0] == 2'h0 && idx_ok(wr_idx);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_held_r <= 1'b0;
      wdata_r  <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata_i[7:0];
      wstrb0_r <= s_axi_wstrb_i[0];
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= zac_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_acc_hit || wr_psel_hit) ? zac_pkg::RESP_OKAY : zac_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o  = bresp_r;

  // Zone registers; the checker reads them live, so a write acts at once
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_ZONES; i++) begin
        acc_r[i]  <= zac_pkg::ACC_RESET; // [RULE7] [RULE9]
        psel_r[i] <= zac_pkg::PSEL_RESET; // [RULE7]
      end
    end else if (do_write && wstrb0_r) begin
      if (wr_acc_hit) begin
        acc_r[wr_idx] <= wdata_r; // [RULE8] [RULE10] [RULE11]
      end
      if (wr_psel_hit) begin
        psel_r[wr_idx] <= wdata_r; // [RULE8]
      end
    end
  end

  // AXI4-Lite read
  assign s_axi_arready_o = !rvalid_r;
  assign rd_idx          = s_axi_araddr_i[zac_pkg::ZONE_W+1:2];

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b0;
    if (s_axi_araddr_i[1:0] == 2'h0) begin
      if (s_axi_araddr_i[zac_pkg::ADDR_W-1:6] == zac_pkg::ACC_BASE[zac_pkg::ADDR_W-1:6]
          && idx_ok(rd_idx)) begin
        rd_hit  = 1'b1;
        rd_data = {24'h000000, acc_r[rd_idx]};
      end else if (s_axi_araddr_i[zac_pkg::ADDR_W-1:6] == zac_pkg::PSEL_BASE[zac_pkg::ADDR_W-1:6]
                   && idx_ok(rd_idx)) begin
        rd_hit  = 1'b1;
        rd_data = {24'h000000, psel_r[rd_idx]};
      end else if (s_axi_araddr_i == zac_pkg::STATUS_ADDR) begin
        rd_hit                        = 1'b1;
        rd_data[zac_pkg::STAT_FACTORY] = fuses_i.factory_lock_fuse;
        rd_data[zac_pkg::STAT_CIPHER]  = fuses_i.cipher_lock_fuse;
        rd_data[zac_pkg::STAT_SKEY]    = fuses_i.secret_key_fuse;
        rd_data[zac_pkg::STAT_FINAL]   = fuses_i.final_lock_fuse;
        rd_data[zac_pkg::STAT_GRANT]   = resp_grant_r;
        rd_data[zac_pkg::STAT_ERROR]   = resp_error_r;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= zac_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data;
      rresp_r  <= rd_hit ? zac_pkg::RESP_OKAY : zac_pkg::RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o  = rdata_r;
  assign s_axi_rresp_o  = rresp_r;

  // User zone check; an out-of-range zone is refused below
  assign zone_in_range = idx_ok(req_i.zone);
  assign zone_acc      = zone_in_range ? acc_r[req_i.zone] : zac_pkg::ACC_RESET; // [RULE8]
  assign zone_set      = zone_in_range ? psel_r[req_i.zone][zac_pkg::SET_W-1:0]
                                       : '0; // [RULE13]

  zac_zone_check u_zone_check (
    .write_i       (req_i.write),
    .access_i      (zone_acc),
    .single_byte_i (req_i.single_byte),
    .byte_sel_i    (req_i.byte_sel),
    .lock_byte_i   (req_i.lock_byte),
    .old_data_i    (req_i.old_data),
    .new_data_i    (req_i.new_data),
    .write_pw_ok_i (session_i.write_pw_ok[zone_set]),
    .read_pw_ok_i  (session_i.read_pw_ok[zone_set]),
    .auth_ok_i     (session_i.auth_ok),
    .encrypt_on_i  (session_i.encrypt_on),
    .allow_o       (zone_allow),
    .data_o        (zone_data)
  );

  // Fuses are blown in a fixed order, so later fuses are tested first
  assign enc_phase   = !fuses_i.cipher_lock_fuse && fuses_i.secret_key_fuse;
  assign sky_blown   = !fuses_i.secret_key_fuse;
  assign per_blown   = !fuses_i.final_lock_fuse;
  assign tpw         = session_i.transport_ok;
  assign own_set_wpw = session_i.write_pw_ok[req_i.set];

  always_comb begin
    unique case (req_i.area)
      zac_pkg::AREA_USER:     allow = zone_in_range && zone_allow;
      zac_pkg::AREA_ANTICOL:  allow = !req_i.write || (!per_blown && tpw); // [RULE1] [RULE6]
      zac_pkg::AREA_ACCESS:   allow = !req_i.write || (!per_blown && tpw); // [RULE6]
      zac_pkg::AREA_MTZ:      allow = 1'b1; // [RULE6]
      zac_pkg::AREA_HWR:      allow = !req_i.write; // [RULE4]
      zac_pkg::AREA_SERIAL:   allow = !req_i.write; // [RULE4]
      zac_pkg::AREA_DCR:      allow = !req_i.write || (!sky_blown && tpw); // [RULE6]
      zac_pkg::AREA_CRYPTO:   allow = !req_i.write || (!sky_blown && tpw); // [RULE5]
      zac_pkg::AREA_KEYS:     allow = !sky_blown && tpw
                                      && (!enc_phase || session_i.encrypt_on); // [RULE3]
      zac_pkg::AREA_SECRET:   allow = !sky_blown && tpw
                                      && (!enc_phase || session_i.encrypt_on); // [RULE3]
      zac_pkg::AREA_PASSWORD: allow = per_blown ? own_set_wpw // [RULE2]
                                      : tpw && (!enc_phase || session_i.encrypt_on); // [RULE1]
      zac_pkg::AREA_PAC:      allow = !req_i.write || (per_blown ? own_set_wpw : tpw); // [RULE2]
      zac_pkg::AREA_FORBIDDEN: allow = 1'b0; // [RULE6]
      default:                allow = 1'b0;
    endcase
  end

  // Answer one cycle after the request; a refusal carries no data
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_valid_r <= 1'b0;
      resp_grant_r <= 1'b0;
      resp_error_r <= 1'b0;
      resp_data_r  <= 8'h00;
    end else begin
      resp_valid_r <= req_valid_i;
      if (req_valid_i) begin
        resp_grant_r <= allow;
        resp_error_r <= !allow; // [RULE19]
        resp_data_r  <= !allow ? 8'h00 : (req_i.area == zac_pkg::AREA_USER && req_i.write)
                        ? zone_data : req_i.new_data; // [RULE19]
      end
    end
  end

  assign resp_valid_o = resp_valid_r;
  assign resp_grant_o = resp_grant_r;
  assign resp_error_o = resp_error_r;
  assign resp_data_o  = resp_data_r;

  sequence user_write_s;
    req_valid_i && req_i.area == zac_pkg::AREA_USER && req_i.write && zone_in_range;
  endsequence

  sequence refused_s;
    resp_valid_o && resp_error_o && !resp_grant_o && resp_data_o == 8'h00;
  endsequence

  error_no_data_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE19]
    resp_valid_o && !resp_grant_o |-> resp_error_o && resp_data_o == 8'h00)
    else $error("refused answer carries data");

  forbidden_area_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE6]
    req_valid_i && req_i.area == zac_pkg::AREA_FORBIDDEN |=> refused_s)
    else $error("forbidden area granted");

  serial_readonly_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE4]
    req_valid_i && req_i.area == zac_pkg::AREA_SERIAL |=> resp_grant_o == !$past(req_i.write))
    else $error("serial number access wrong");

  transport_needed_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE1]
    req_valid_i && req_i.area == zac_pkg::AREA_ANTICOL && req_i.write && !tpw |=> refused_s)
    else $error("write granted without transport password");

  encrypt_needed_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE3]
    req_valid_i && req_i.area == zac_pkg::AREA_KEYS && enc_phase && !session_i.encrypt_on
    |=> refused_s)
    else $error("key access granted without encryption");

  crypto_locked_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE5]
    req_valid_i && req_i.area == zac_pkg::AREA_CRYPTO && req_i.write && sky_blown |=> refused_s)
    else $error("crypto write after key fuse");

  modify_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE17]
    user_write_s ##0 !zone_acc[zac_pkg::MDF_BIT] |=> refused_s)
    else $error("write granted to modify-forbidden zone");

  program_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE18]
    user_write_s ##0 !zone_acc[zac_pkg::PGO_BIT] |=>
    !resp_grant_o || resp_data_o == ($past(req_i.old_data) & $past(req_i.new_data)))
    else $error("program-only write set a bit");

  open_default_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE11]
    req_valid_i && req_i.area == zac_pkg::AREA_USER && zone_in_range
    && zone_acc == zac_pkg::ACC_RESET |=> resp_grant_o)
    else $error("open zone refused");

  own_set_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE2]
    req_valid_i && req_i.area == zac_pkg::AREA_PAC && req_i.write && per_blown && !own_set_wpw
    |=> refused_s)
    else $error("counter write granted without own set password");

  reserved_mode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE15]
    req_valid_i && req_i.area == zac_pkg::AREA_USER && !zone_acc[zac_pkg::ENC_BIT]
    && !(zone_acc[zac_pkg::AUTH_HI] && zone_acc[zac_pkg::AUTH_LO]) |=> refused_s)
    else $error("reserved security mode granted");

  lock_byte_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RULE16]
    user_write_s ##0 (!zone_acc[zac_pkg::WLM_BIT] && !req_i.lock_byte[req_i.byte_sel])
    |=> refused_s)
    else $error("write granted to locked byte");

endmodule

/* verification/zac_reader.sv */
`timescale 1ns/10ps
module zac_reader (
  input  wire logic             clk_i,
  output logic                  req_valid_o,
  output zac_pkg::zac_req_s     req_o,
  output zac_pkg::zac_session_s sess_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
    sess_o = '0;
  end

  // Session is set up one cycle ahead of the request
  task automatic send(input zac_pkg::zac_req_s r, input zac_pkg::zac_session_s s);
    @(posedge clk_i);
    sess_o <= s;
    @(posedge clk_i);
    req_o <= r;
    req_valid_o <= 1'b1;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    // Released payload flips so stale values are never trusted
    req_o <= ~r;
  endtask
endmodule

/* verification/zone_access_control_bench.sv */
`timescale 1ns/10ps
module zone_access_control_bench;
  localparam logic [1:0] OK  = zac_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = zac_pkg::RESP_SLVERR;
  logic                  clk_sys_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  logic [11:0]           awaddr = '0;
  logic [11:0]           araddr = '0;
  logic [31:0]           wdata = '0;
  logic [3:0]            wstrb = 4'hF;
  logic                  awv = 1'b0;
  logic                  wv = 1'b0;
  logic                  bready = 1'b0;
  logic                  arv = 1'b0;
  logic                  rready = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid, resp_v, gr, er;
  logic [1:0]            bresp, rresp;
  logic [31:0]           rdata;
  logic [7:0]            rd8;
  logic                  req_valid;
  zac_pkg::zac_req_s     req, r;
  zac_pkg::zac_session_s sess, s;
  zac_pkg::zac_fuse_s    fu = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic [33:0]           rq[$];
  logic [33:0]           aq[$];
  logic [1:0]            bq[$];
  int                    fails = 0;
  int                    n_compared = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  zac_reader rdr (.clk_i(clk_sys_i), .req_valid_o(req_valid), .req_o(req), .sess_o(sess));

  zac_top uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .req_valid_i(req_valid),
    .req_i(req), .session_i(sess), .fuses_i(fu), .resp_valid_o(resp_v),
    .resp_grant_o(gr), .resp_error_o(er), .resp_data_o(rd8)
  );

  task automatic cmp_rd(input logic [33:0] e);
    n_compared++;
    if (e !== {rresp, rdata}) begin
      fails++;
      $display("MISMATCH rdata expected %h seen %h", e, {rresp, rdata});
    end
  endtask

  task automatic cmp_wr(input logic [1:0] e);
    n_compared++;
    if (e !== bresp) begin
      fails++;
      $display("MISMATCH bresp expected %h seen %h", e, bresp);
    end
  endtask

  task automatic cmp_acc(input logic [33:0] e);
    n_compared++;
    if (e !== {24'h0, gr, er, rd8}) begin
      fails++;
      $display("MISMATCH resp expected %h seen %h", e, {24'h0, gr, er, rd8});
    end
  endtask

  task final_report;
    // Answers that never came count as mismatches
    fails += rq.size() + aq.size() + bq.size();
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Outputs are sampled mid-cycle, well clear of the launching edge
  always @(negedge clk_sys_i) begin
    if (rvalid === 1'b1 && rready) cmp_rd(rq.pop_front());
    if (bvalid === 1'b1 && bready) cmp_wr(bq.pop_front());
    if (resp_v === 1'b1) cmp_acc(aq.pop_front());
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    logic [2:0] k;
    bq.push_back(e);
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      k = {awready, wready, bvalid};
      @(posedge clk_sys_i);
      if (k[2]) awv <= 1'b0;
      if (k[1]) wv <= 1'b0;
    end while (k[0] !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    logic [1:0] k;
    rq.push_back(e);
    @(posedge clk_sys_i);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      k = {arready, rvalid};
      @(posedge clk_sys_i);
      if (k[1]) arv <= 1'b0;
    end while (k[0] !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic go(input logic g, input logic [7:0] d);
    aq.push_back({24'h0, g, ~g, (g ? d : 8'h00)});
    rdr.send(r, s);
  endtask

  initial begin
    #100000;
    fails++;
    final_report;
  end

  initial begin
    void'($urandom(32'h6105));
    r = '0;
    s = '0;
    r.single_byte = 1'b1;
    r.lock_byte = 8'hFF;
    r.old_data = 8'hFF;
    r.new_data = 8'($urandom);
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(zac_pkg::ACC_BASE, {OK, 32'hFF});
    rd(zac_pkg::PSEL_BASE + 12'h03C, {OK, 32'hFF});
    rd(12'h0FC, {ERR, 32'h0});
    go(1'b1, r.new_data);
    r.write = 1'b1;
    go(1'b1, r.new_data);
    r.area = zac_pkg::AREA_ANTICOL;
    go(1'b0, 8'h00);
    s.transport_ok = 1'b1;
    go(1'b1, r.new_data);
    r.area = zac_pkg::AREA_SERIAL;
    go(1'b0, 8'h00);
    r.area = zac_pkg::AREA_HWR;
    go(1'b0, 8'h00);
    r.write = 1'b0;
    s = '0;
    go(1'b1, r.new_data);
    r.area = zac_pkg::AREA_MTZ;
    r.write = 1'b1;
    go(1'b1, r.new_data);
    r.area = zac_pkg::AREA_FORBIDDEN;
    s.transport_ok = 1'b1;
    go(1'b0, 8'h00);
    r.area = zac_pkg::AREA_CRYPTO;
    go(1'b1, r.new_data);
    @(posedge clk_sys_i) fu.cipher_lock_fuse <= 1'b0;
    r.area = zac_pkg::AREA_KEYS;
    r.write = 1'b0;
    go(1'b0, 8'h00);
    s.encrypt_on = 1'b1;
    go(1'b1, r.new_data);
    @(posedge clk_sys_i) fu.secret_key_fuse <= 1'b0;
    r.area = zac_pkg::AREA_CRYPTO;
    r.write = 1'b1;
    go(1'b0, 8'h00);
    r.area = zac_pkg::AREA_DCR;
    go(1'b0, 8'h00);
    r.area = zac_pkg::AREA_ANTICOL;
    go(1'b1, r.new_data);
    @(posedge clk_sys_i) fu.final_lock_fuse <= 1'b0;
    go(1'b0, 8'h00);
    r.area = zac_pkg::AREA_PAC;
    r.set = 3'h2;
    s = '0;
    s.write_pw_ok = 8'h04;
    go(1'b1, r.new_data);
    r.set = 3'h3;
    go(1'b0, 8'h00);
    r.area = zac_pkg::AREA_PASSWORD;
    go(1'b0, 8'h00);
    r.set = 3'h2;
    go(1'b1, r.new_data);
    rd(zac_pkg::STATUS_ADDR, {OK, 32'h10});
    wr(zac_pkg::STATUS_ADDR, 8'h00, ERR);
    @(posedge clk_sys_i) fu <= '{1'b0, 1'b1, 1'b1, 1'b1};
    r.area = zac_pkg::AREA_USER;
    s = '0;
    wr(zac_pkg::ACC_BASE + 12'h00C, 8'hFD, OK);
    rd(zac_pkg::ACC_BASE + 12'h00C, {OK, 32'hFD});
    r.zone = 4'h3;
    go(1'b0, 8'h00);
    r.zone = 4'h4;
    go(1'b1, r.new_data);
    wr(zac_pkg::ACC_BASE + 12'h014, 8'hBF, OK);
    wr(zac_pkg::PSEL_BASE + 12'h014, 8'h02, OK);
    r.zone = 4'h5;
    s.write_pw_ok = 8'h80;
    go(1'b0, 8'h00);
    s.write_pw_ok = 8'h04;
    go(1'b1, r.new_data);
    wr(zac_pkg::ACC_BASE + 12'h014, 8'h3F, OK);
    r.write = 1'b0;
    s = '0;
    go(1'b0, 8'h00);
    s.read_pw_ok = 8'h04;
    go(1'b1, r.new_data);
    wr(zac_pkg::ACC_BASE + 12'h018, 8'hFE, OK);
    r.zone = 4'h6;
    r.write = 1'b1;
    r.old_data = 8'hA5;
    go(1'b1, 8'hA5 & r.new_data);
    r.single_byte = 1'b0;
    go(1'b0, 8'h00);
    wr(zac_pkg::ACC_BASE + 12'h01C, 8'hFB, OK);
    r.zone = 4'h7;
    r.single_byte = 1'b1;
    r.byte_sel = 3'h5;
    r.lock_byte = 8'hDF;
    go(1'b0, 8'h00);
    r.lock_byte = 8'h20;
    go(1'b1, r.new_data);
    r.zone = 4'h8;
    r.write = 1'b0;
    for (int c = 0; c < 8; c++) begin
      r.new_data = 8'($urandom);
      s.auth_ok = 1'b0;
      s.encrypt_on = 1'b0;
      wr(zac_pkg::ACC_BASE + 12'h020, {2'h3, 3'(c), 3'h7}, OK);
      go(c == 5 || c == 7, r.new_data);
      // Authenticated and encrypted: every supported mode opens
      s.auth_ok = 1'b1;
      s.encrypt_on = 1'b1;
      go(c % 2 == 1 || c == 6, r.new_data);
    end
    repeat (4) @(posedge clk_sys_i);
    final_report;
  end
endmodule
